// >>> design/idc_distributor_regs.sv
/*
  Interrupt distributor slice: identification register, trigger
  configuration bit-pairs, private-line status and shared-line status,
  reached over APB, plus per-line sensing of the shared inputs and a small
  event interrupt.
  Assumes: all inputs synchronous to pclk; pcore_id names the requesting
  core and pprot[1] marks a non-secure access; group assignments come from
  the group register block outside.
*/
//
// Contract
// - Identification is read-only: product code in 31:24, implementer 11:0.
// - Identification holds major in 19:16, minor in 15:12; 23:20 zero.
// - Configuration registers give one two-bit field per interrupt.
// - Software-generated pairs are read-only and read binary 10.
// - Private per-core pairs are read-only and read binary 01; the code reads 00 in fields 0 to 8 (identifiers 16 to 24).
// - Shared pairs: low bit reads one, high bit software writable.
// - Shared pair 01 senses high level; 11 senses rising edge.
// - Private status shows seven inputs in 15:9; other bits zero.
// - Private order 6..0: maint, hyp, virt, irq, ns, s timer, fiq.
// - Non-secure private status read shows group 1 bits only.
// - Private status read returns only the requesting core's lines.
// - Private status shows raw levels, independent of pending state.
// - Shared status shows up to 480 lines; non-secure sees group 1.
// - Shared status bit is the line level; offset and bit pick it.
// - Fewer shared lines shrink registers; missing bits read zero.
// - Identifiers 0 to 31 are private kinds; shared start at 32.
`timescale 1ns/1ns
`default_nettype none
module idc_distributor_regs
  import idc_pkg::*;
#(
  parameter int unsigned SHARED_IMPL  = NUM_SHARED,
  parameter logic [7:0]  PRODUCT_CODE = 8'h5a,   // Arbitrary value
  parameter logic [3:0]  MAJOR_REV    = 4'h3,    // Arbitrary value
  parameter logic [3:0]  MINOR_REV    = 4'h2,    // Arbitrary value
  parameter logic [11:0] IMPL_CODE    = 12'h2c7  // Arbitrary value
) (
  // Clock, reset, enable
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            ce,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [11:0]                     paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic [3:0]                      pstrb,
  input  wire logic [2:0]                      pprot,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Requesting core
  input  wire logic [CORE_W-1:0]               pcore_id,
  // Raw interrupt lines
  input  wire logic [NUM_CORES*NUM_PRIV-1:0]   private_core_irq,
  input  wire logic [NUM_SHARED-1:0]           shared_irq_inputs,
  // Group 1 assignment from the group registers
  input  wire logic [NUM_CORES*NUM_PRIV-1:0]   private_group1,
  input  wire logic [NUM_SHARED-1:0]           shared_group1,
  // Sensed shared requests and trigger modes
  output logic      [NUM_SHARED-1:0]           shared_irq_sensed,
  output logic      [NUM_SHARED-1:0]           shared_edge_mode,
  // Event interrupt
  output logic                                 irq
);

  // ==========================================================
  // Constants derived from the build
  // ==========================================================
  localparam logic [NUM_SHARED-1:0] IMPL_MASK =
    {NUM_SHARED{1'b1}} >> (NUM_SHARED - SHARED_IMPL);
  localparam logic [31:0] IDENT_VALUE =
    (32'(PRODUCT_CODE) << ID_PRODUCT_LSB) |
    (32'(MAJOR_REV) << ID_MAJOR_LSB) |
    (32'(MINOR_REV) << ID_MINOR_LSB) |
    (32'(IMPL_CODE) << ID_IMPL_LSB);

  // ==========================================================
  // Declarations
  // ==========================================================
  idc_apb_state_t          state_r;
  idc_apb_state_t          state_nxt;
  logic [31:0]             prdata_r;
  logic [31:0]             prdata_nxt;
  logic [NUM_SHARED-1:0]   cfg_hi_r;
  logic [NUM_SHARED-1:0]   cfg_hi_nxt;
  logic [31:0]             read_value;
  logic                    setup_rd;
  logic                    access_wr;
  logic                    nonsec;
  logic                    in_cfg;
  logic                    in_shared;
  logic [4:0]              cfg_idx;
  logic [8:0]              cfg_base;
  logic [3:0]              sh_idx;
  logic [8:0]              sh_base;
  logic [NUM_PRIV-1:0]     own_lines;
  logic [NUM_PRIV-1:0]     own_group;
  logic [NUM_SHARED-1:0]   shared_vis;
  logic [NUM_CORES*NUM_PRIV-1:0] priv_rise;
  logic [NUM_EV-1:0]       ev_in;
  logic [NUM_EV-1:0]       ev_clear;
  logic [NUM_EV-1:0]       ev_status;
  logic [NUM_EV-1:0]       ev_mask;
  logic                    mask_we;

  // ==========================================================
  // Access decode
  // ==========================================================
  // Every access finishes in its first access cycle, so pready stays high
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  assign nonsec    = pprot[1];
  assign setup_rd  = psel && !penable && !pwrite;
  assign access_wr = (state_r == IDC_ACCESS) && psel && penable && pwrite;

  // Region and index of the configuration block
  assign in_cfg   = (paddr[11:7] == OFF_CFG_BASE[11:7]);
  assign cfg_idx  = paddr[6:2];
  assign cfg_base = {5'(cfg_idx - 5'h2), 4'h0};

  // Shared status words follow the private status word
  assign in_shared = (paddr[11:6] == OFF_PRIV_STAT[11:6]) &&
                     (paddr[5:2] != 4'h0) &&
                     (paddr[5:2] <= 4'(SHARED_REGS));
  assign sh_idx    = 4'(paddr[5:2] - 4'h1);
  assign sh_base   = {sh_idx, 5'h00};

  // Own core's private lines and group bits only
  assign own_lines = private_core_irq[pcore_id*NUM_PRIV +: NUM_PRIV];
  assign own_group = private_group1[pcore_id*NUM_PRIV +: NUM_PRIV];

  // Shared lines visible to this access
  assign shared_vis = shared_irq_inputs & IMPL_MASK &
                      (nonsec ? shared_group1 : {NUM_SHARED{1'b1}});

  // ==========================================================
  // Bus phase state
  // ==========================================================
  // Tracks setup then access so a write lands only once per transfer
  always_comb begin
    case (state_r)
      IDC_IDLE: begin
        state_nxt = (psel && !penable) ? IDC_ACCESS : IDC_IDLE;
      end
      IDC_ACCESS: begin
        state_nxt = (psel && !penable) ? IDC_ACCESS : IDC_IDLE;
      end
      default: begin
        state_nxt = IDC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= IDC_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Read value
  // ==========================================================
  // Unmapped offsets and missing lines read zero
  always_comb begin
    read_value = 32'h0000_0000;
    if (paddr == OFF_IDENT) begin
      read_value = IDENT_VALUE;
    end else if (in_cfg) begin
      if (cfg_idx == 5'h00) begin
        read_value = CFG_SW_VALUE;
      end else if (cfg_idx == 5'h01) begin
        read_value = CFG_PRIV_VALUE;
      end else begin
        for (int k = 0; k < FIELDS_PER_CFG; k++) begin
          // Low bit one for implemented lines, zero for missing ones; high bit from storage
          read_value[2*k]   = IMPL_MASK[cfg_base + 9'(k)];
          read_value[2*k+1] = cfg_hi_r[cfg_base + 9'(k)];
        end
      end
    end else if (paddr == OFF_PRIV_STAT) begin
      // Raw line levels, never the pending state
      read_value[PRIV_STAT_LSB +: NUM_PRIV] =
        own_lines & (nonsec ? own_group : {NUM_PRIV{1'b1}});
    end else if (in_shared) begin
      read_value = shared_vis[sh_base +: 32];
    end else if (paddr == OFF_IRQ_STATUS) begin
      read_value[NUM_EV-1:0] = ev_status;
    end else if (paddr == OFF_IRQ_MASK) begin
      read_value[NUM_EV-1:0] = ev_mask;
    end
  end

  // ==========================================================
  // Read data register
  // ==========================================================
  // Captured in the setup cycle so prdata is a flop in the access cycle
  always_comb begin
    prdata_nxt = setup_rd ? read_value : prdata_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (ce) begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // ==========================================================
  // Trigger configuration storage
  // ==========================================================
  // Only the high bit of implemented shared pairs holds state; writes to
  // the fixed words and to missing lines fall away silently
  always_comb begin
    cfg_hi_nxt = cfg_hi_r;
    if (access_wr && in_cfg && (cfg_idx >= 5'h02)) begin
      for (int k = 0; k < FIELDS_PER_CFG; k++) begin
        if (pstrb[k/4] && IMPL_MASK[cfg_base + 9'(k)]) begin
          cfg_hi_nxt[cfg_base + 9'(k)] = pwdata[2*k+1];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_hi_r <= {NUM_SHARED{CFG_HI_RST}};
    end else if (ce) begin
      cfg_hi_r <= cfg_hi_nxt;
    end
  end

  assign shared_edge_mode = cfg_hi_r & IMPL_MASK;

  // ==========================================================
  // Line sensing
  // ==========================================================
  // Pair 11 gives a rising-edge pulse, pair 01 passes the level
  idc_line_sense #(
    .WIDTH     (NUM_SHARED)
  ) u_shared_sense (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .line      (shared_irq_inputs & IMPL_MASK),
    .edge_mode (shared_edge_mode),
    .sensed    (shared_irq_sensed)
  );

  // Private lines feed only the rise event here
  idc_line_sense #(
    .WIDTH     (NUM_CORES*NUM_PRIV)
  ) u_priv_rise (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .line      (private_core_irq),
    .edge_mode ({(NUM_CORES*NUM_PRIV){1'b1}}),
    .sensed    (priv_rise)
  );

  // ==========================================================
  // Event interrupt
  // ==========================================================
  // Events: an edge-mode shared line fired, or any private line rose
  always_comb begin
    ev_in                 = '0;
    ev_in[EV_SHARED_EDGE] = |(shared_irq_sensed & shared_edge_mode);
    ev_in[EV_PRIV_RISE]   = |priv_rise;
    ev_clear              = '0;
    if (access_wr && (paddr == OFF_IRQ_STATUS) && pstrb[0]) begin
      ev_clear = pwdata[NUM_EV-1:0];
    end
  end

  assign mask_we = access_wr && (paddr == OFF_IRQ_MASK) && pstrb[0];

  idc_event_irq #(
    .WIDTH      (NUM_EV)
  ) u_event_irq (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .event_in   (ev_in),
    .clear      (ev_clear),
    .mask_we    (mask_we),
    .mask_wdata (pwdata[NUM_EV-1:0]),
    .status     (ev_status),
    .mask       (ev_mask),
    .irq        (irq)
  );

endmodule : idc_distributor_regs
`default_nettype wire

// >>> inc/idc_pkg.sv
/*
  Shared constants of the interrupt distributor identification, trigger
  configuration and input status block: register offsets, field positions,
  fixed read values, line counts and the bus state encoding.
  Assumes a 12-bit APB byte address window and 32-bit data.
*/
`default_nettype none
package idc_pkg;

  // ==========================================================
  // Register offsets (byte addresses, one aligned word each)
  // ==========================================================
  localparam logic [11:0] OFF_IDENT       = 12'h008;
  localparam logic [11:0] OFF_CFG_BASE    = 12'hc00;
  localparam logic [11:0] OFF_PRIV_STAT   = 12'hd00;
  localparam logic [11:0] OFF_SHARED_BASE = 12'hd04;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'hf00;
  localparam logic [11:0] OFF_IRQ_MASK    = 12'hf04;
  localparam int unsigned CFG_REGS        = 32;
  localparam int unsigned SHARED_REGS     = 15;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int unsigned ID_PRODUCT_LSB = 24;
  localparam int unsigned ID_MAJOR_LSB   = 16;
  localparam int unsigned ID_MINOR_LSB   = 12;
  localparam int unsigned ID_IMPL_LSB    = 0;
  localparam int unsigned PRIV_STAT_LSB  = 9;

  // ==========================================================
  // Line counts and identifier layout
  // ==========================================================
  localparam int unsigned NUM_CORES       = 4;
  localparam int unsigned CORE_W          = 2;
  localparam int unsigned NUM_PRIV        = 7;
  localparam int unsigned NUM_SHARED      = 480;
  localparam int unsigned FIRST_SHARED_ID = 32;
  localparam int unsigned FIELDS_PER_CFG  = 16;

  // Private line order inside one core's group
  localparam int unsigned PRIV_VIRT_MAINT = 6;
  localparam int unsigned PRIV_HYP_TIMER  = 5;
  localparam int unsigned PRIV_VIRT_TIMER = 4;
  localparam int unsigned PRIV_LEGACY_IRQ = 3;
  localparam int unsigned PRIV_NS_TIMER   = 2;
  localparam int unsigned PRIV_S_TIMER    = 1;
  localparam int unsigned PRIV_LEGACY_FIQ = 0;

  // ==========================================================
  // Fixed read values and reset values
  // ==========================================================
  localparam logic [31:0] CFG_SW_VALUE   = 32'haaaaaaaa;
  localparam logic [31:0] CFG_PRIV_VALUE = 32'h55540000;
  localparam logic        CFG_HI_RST     = 1'b0;
  localparam logic [1:0]  IRQ_MASK_RST   = 2'h0;

  // Event bits of the status and mask registers
  localparam int unsigned NUM_EV         = 2;
  localparam int unsigned EV_SHARED_EDGE = 0;
  localparam int unsigned EV_PRIV_RISE   = 1;

  // Bus phase tracking
  typedef enum logic [1:0] {
    IDC_IDLE   = 2'b01,
    IDC_ACCESS = 2'b10
  } idc_apb_state_t;

endpackage : idc_pkg
`default_nettype wire

// >>> design/idc_line_sense.sv
/*
  Per-line sensing: each line is either passed as a level or turned into a
  one-cycle pulse on its rising edge, chosen per line by edge_mode.
  Assumes lines are synchronous to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module idc_line_sense #(
  parameter int unsigned WIDTH = 1
) (
  // Clock, reset, enable
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Lines and mode
  input  wire logic [WIDTH-1:0] line,
  input  wire logic [WIDTH-1:0] edge_mode,
  // Result
  output logic      [WIDTH-1:0] sensed
);

  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] prev_nxt;
  logic [WIDTH-1:0] sensed_r;
  logic [WIDTH-1:0] sensed_nxt;

  // ==========================================================
  // Next values
  // ==========================================================
  // A line already high at reset release counts as one rising edge
  always_comb begin
    prev_nxt   = line;
    sensed_nxt = (edge_mode & line & ~prev_r) | (~edge_mode & line);
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r   <= '0;
      sensed_r <= '0;
    end else if (ce) begin
      prev_r   <= prev_nxt;
      sensed_r <= sensed_nxt;
    end
  end

  assign sensed = sensed_r;

endmodule : idc_line_sense
`default_nettype wire

// >>> design/idc_event_irq.sv
/*
  Sticky event status with a mask and one level interrupt output.
  Assumes clear pulses come from write-one-to-clear bus writes.
*/
`timescale 1ns/1ns
`default_nettype none
module idc_event_irq
  import idc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  // Clock, reset, enable
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Events and software controls
  input  wire logic [WIDTH-1:0] event_in,
  input  wire logic [WIDTH-1:0] clear,
  input  wire logic             mask_we,
  input  wire logic [WIDTH-1:0] mask_wdata,
  // State and interrupt
  output logic      [WIDTH-1:0] status,
  output logic      [WIDTH-1:0] mask,
  output logic                  irq
);

  logic [WIDTH-1:0] status_r;
  logic [WIDTH-1:0] status_nxt;
  logic [WIDTH-1:0] mask_r;
  logic [WIDTH-1:0] mask_nxt;

  // ==========================================================
  // Next values
  // ==========================================================
  // Set wins over clear so an event in the clearing cycle survives
  always_comb begin
    status_nxt = (status_r & ~clear) | event_in;
    mask_nxt   = mask_we ? mask_wdata : mask_r;
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      mask_r   <= WIDTH'(IRQ_MASK_RST);
    end else if (ce) begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
    end
  end

  assign status = status_r;
  assign mask   = mask_r;
  assign irq    = |(status_r & mask_r);

endmodule : idc_event_irq
`default_nettype wire

// >>> verification/idc_chk.sv
/*
  Checker of the distributor register slice: bus answer, fixed read
  values, private status, line sensing and the event interrupt.
  Assumes it sees only the top ports; bound at the foot of the file.
*/
`timescale 1ns/1ns
`default_nettype none
module idc_chk
  import idc_pkg::*;
(
  // Clock and reset
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          ce,
  // Bus
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [11:0]                   paddr,
  input wire logic [3:0]                    pstrb,
  input wire logic [2:0]                    pprot,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire logic [CORE_W-1:0]             pcore_id,
  // Lines
  input wire logic [NUM_CORES*NUM_PRIV-1:0] private_core_irq,
  input wire logic [NUM_CORES*NUM_PRIV-1:0] private_group1,
  input wire logic [NUM_SHARED-1:0]         shared_irq_inputs,
  input wire logic [NUM_SHARED-1:0]         shared_irq_sensed,
  input wire logic [NUM_SHARED-1:0]         shared_edge_mode,
  input wire logic                          irq
);
  // ========================================
  // Helpers
  logic       rd_set;
  logic       wr_acc;
  logic       st_wr;
  logic       cfg_wr;
  logic [6:0] own_lines;
  assign rd_set = psel && !penable && !pwrite && ce;
  assign wr_acc = psel && penable && pwrite && ce;
  // Writes that may lower the interrupt or move a trigger mode
  assign st_wr  = wr_acc && pstrb[0] && paddr[11:4] == OFF_IRQ_STATUS[11:4];
  assign cfg_wr = wr_acc && paddr[11:8] == 4'hc;
  // Requesting core's lines, hidden by group for non-secure reads
  assign own_lines = 7'(private_core_irq >> (NUM_PRIV * pcore_id))
    & (pprot[1] ? 7'(private_group1 >> (NUM_PRIV * pcore_id)) : 7'h7f);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ========================================
  // Assertions
  bus_answer_a: assert property (pready && !pslverr)
    else $error("bus answer not ready or flagged error");
  ident_rsvd_a: assert property (
    rd_set && paddr == OFF_IDENT |=> prdata[23:20] == 4'h0)
    else $error("identification reserved bits not zero");
  cfg_soft_a: assert property (
    rd_set && paddr == OFF_CFG_BASE |=> prdata == CFG_SW_VALUE)
    else $error("software pairs read wrong");
  cfg_priv_a: assert property (
    rd_set && paddr == OFF_CFG_BASE + 12'h4 |=> prdata == CFG_PRIV_VALUE)
    else $error("private pairs read wrong");
  priv_stat_a: assert property (rd_set && paddr == OFF_PRIV_STAT
    |=> prdata == {16'h0, $past(own_lines), 9'h0})
    else $error("private status read wrong");
  // Sampled reset keeps the release edge out: the flops still reset there
  level_sense_a: assert property (ce && presetn
    && !shared_edge_mode[20]
    |=> shared_irq_sensed[20] == $past(shared_irq_inputs[20]))
    else $error("level line not passed through");
  edge_pulse_a: assert property (ce && $past(ce)
    && shared_edge_mode[0] && $rose(shared_irq_inputs[0])
    |=> shared_irq_sensed[0] ##1 !shared_irq_sensed[0])
    else $error("rising edge not one pulse");
  irq_fall_a: assert property ($fell(irq) |-> $past(st_wr))
    else $error("interrupt fell without a write");
  mode_write_a: assert property (
    !$stable(shared_edge_mode) |-> $past(cfg_wr))
    else $error("trigger mode changed without a write");
endmodule : idc_chk

bind idc_distributor_regs idc_chk u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb),
  .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pcore_id(pcore_id), .private_core_irq(private_core_irq),
  .private_group1(private_group1), .shared_irq_inputs(shared_irq_inputs),
  .shared_irq_sensed(shared_irq_sensed),
  .shared_edge_mode(shared_edge_mode), .irq(irq));
`default_nettype wire

// >>> verification/idc_src_model.sv
/*
  Interrupt sources: private per-core and shared lines, moved to the
  levels the bench asks for just after each clock edge.
  Assumes sources are synchronous to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module idc_src_model
  import idc_pkg::*;
(
  // Clock
  input  wire logic                          pclk,
  // Requested levels
  input  wire logic [NUM_CORES*NUM_PRIV-1:0] priv_req,
  input  wire logic [NUM_SHARED-1:0]         shr_req,
  // Lines to the distributor
  output var logic [NUM_CORES*NUM_PRIV-1:0]  private_core_irq = '0,
  output var logic [NUM_SHARED-1:0]          shared_irq_inputs = '0
);
  // Registered so a line never moves on the sampling edge
  always @(posedge pclk) begin
    private_core_irq  <= priv_req;
    shared_irq_inputs <= shr_req;
  end
endmodule : idc_src_model
`default_nettype wire

// >>> verification/idc_distributor_regs_test.sv
/*
  Self-checking bench of the distributor register slice: table of
  register accesses, then status, interrupt, clock-enable and reset cases.
  Assumes 40 shared lines implemented and zero wait states not relied on.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module idc_distributor_regs_test;
  import idc_pkg::*;
  // ========================================
  // Setup
  localparam logic [31:0] ID_EXP = 32'h3c0695e1; // Arbitrary codes
  typedef struct packed {
    logic w; logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;
  } idc_row_t;
  logic        pclk = 0, presetn = 0, ce = 1, irq, pready, pslverr;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q, m;
  logic [3:0]  pstrb = '0;
  logic [2:0]  pprot = '0;
  logic [1:0]  pcore_id = '0;
  logic [27:0] priv_req = 28'h9d2b64e, pgrp = 28'h5a3c0f1, pline;
  logic [479:0] shr_req = {15{32'hc35a96f0}}, sgrp = {15{32'h0ff0f00f}};
  logic [479:0] sline, sensed, emode;
  int          n_errors = 0, n_compared = 0;
  idc_row_t rows [17] = '{
    '{1'b0, 12'h008, 0, 0, ID_EXP}, '{1'b1, 12'h008, '1, 4'hf, 0},
    '{1'b0, 12'h008, 0, 0, ID_EXP}, '{1'b1, 12'hc00, 0, 4'hf, 0},
    '{1'b0, 12'hc00, 0, 0, 32'haaaaaaaa}, '{1'b1, 12'hc04, '1, 4'hf, 0},
    '{1'b0, 12'hc04, 0, 0, 32'h55540000}, '{1'b0, 12'hc08, 0, 0, 32'h55555555},
    '{1'b1, 12'hc08, '1, 4'hf, 0}, '{1'b0, 12'hc08, 0, 0, '1},
    '{1'b1, 12'hc0c, '1, 4'h1, 0}, '{1'b0, 12'hc0c, 0, 0, 32'h555555ff},
    '{1'b1, 12'hc10, '1, 4'hf, 0}, '{1'b0, 12'hc10, 0, 0, 32'h0000ffff},
    '{1'b0, 12'hc14, 0, 0, 0}, '{1'b1, 12'h100, '1, 4'hf, 0},
    '{1'b0, 12'h100, 0, 0, 0}};

  always #25 pclk = ~pclk;

  idc_src_model u_src (.pclk(pclk), .priv_req(priv_req), .shr_req(shr_req),
    .private_core_irq(pline), .shared_irq_inputs(sline));
  idc_distributor_regs #(.SHARED_IMPL(40), .PRODUCT_CODE(ID_EXP[31:24]),
    .MAJOR_REV(ID_EXP[19:16]), .MINOR_REV(ID_EXP[15:12]),
    .IMPL_CODE(ID_EXP[11:0])) DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pcore_id(pcore_id), .private_core_irq(pline),
    .shared_irq_inputs(sline), .private_group1(pgrp),
    .shared_group1(sgrp), .shared_irq_sensed(sensed),
    .shared_edge_mode(emode), .irq(irq));

  // ========================================
  // Tasks
  task automatic summarize;
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // One transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] c, input logic ns);
    int k;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    pcore_id <= c; pprot <= {1'b0, ns, 1'b0};
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 8);
    q = prdata;
    psel <= 0;
    penable <= 0;
    if (k >= 8) begin n_errors++; summarize(); end
  endtask : apb

  // Bounded wait for the interrupt to rise
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 10) begin @(negedge pclk); k++; end
    `CHK(irq, 1'b1)
    // A spent wait goes straight to the verdict
    if (irq !== 1'b1) summarize();
  endtask : wait_irq

  // ========================================
  // Sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rows[i].s, 0, 0);
      if (!rows[i].w) `CHK(q, rows[i].e)
    end
    `CHK(emode[47:0], 48'h00ff000fffff)
    for (int c = 0; c < 4; c++) for (int n = 0; n < 2; n++) begin
      apb(0, OFF_PRIV_STAT, 0, 0, c[1:0], n[0]);
      m = {16'h0, 7'(priv_req >> 7 * c)
        & (n ? 7'(pgrp >> 7 * c) : 7'h7f), 9'h0};
      `CHK(q, m)
    end
    for (int j = 0; j < 3; j++) for (int n = 0; n < 2; n++) begin
      apb(0, OFF_SHARED_BASE + 12'(4 * j), 0, 0, 0, n[0]);
      m = shr_req[32*j+:32] & (j == 0 ? '1 : j == 1 ? 32'hff : 0);
      `CHK(q, m & (n ? sgrp[32*j+:32] : '1))
    end
    // Start-up rises leave events; clear them before unmasking
    apb(1, OFF_IRQ_STATUS, 3, 4'hf, 0, 0);
    apb(1, OFF_IRQ_MASK, 3, 4'hf, 0, 0);
    apb(0, OFF_IRQ_MASK, 0, 0, 0, 0);
    `CHK(q, 32'h3)
    `CHK(irq, 1'b0)
    shr_req[0] <= 1;
    wait_irq();
    apb(0, OFF_IRQ_STATUS, 0, 0, 0, 0);
    `CHK(q, 32'h1)
    apb(1, OFF_IRQ_STATUS, 1, 4'hf, 0, 0);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    priv_req[0] <= 1;
    wait_irq();
    apb(1, OFF_IRQ_MASK, 0, 4'hf, 0, 0);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    apb(0, OFF_IRQ_STATUS, 0, 0, 0, 0);
    `CHK(q, 32'h2)
    // Frozen clock enable must drop the write
    ce <= 0;
    apb(1, 12'hc08, 0, 4'hf, 0, 0);
    ce <= 1;
    apb(0, 12'hc08, 0, 0, 0, 0);
    `CHK(q, 32'hffffffff)
    // Second reset in mid-run returns all pairs to level
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'hc08, 0, 0, 0, 0);
    `CHK(q, 32'h55555555)
    `CHK(irq, 1'b0)
    summarize();
  end
endmodule : idc_distributor_regs_test
`default_nettype wire
